// ### hw/dcrb_top.sv
// Register bank of a 32-channel converter reached over Avalon-MM
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
// Operation
// R1: Thirty-two channels form four groups of eight, addressed by group and channel.
// R2: Each channel owns input data registers A and B of word width.
// R3: Each channel owns gain and offset trim registers of the same width.
// R4: Calibrated A and B hold trimmed results; software cannot read or write them.
// R5: Final converter register loads only from calibrated A or B, never from software.
// R6: A 14-bit offset level sets the output offset of group 0.
// R7: A second 14-bit offset level serves groups 1, 2 and 3.
// R8: Config bit 2 picks input A (0) or B (1) for all data writes.
// R9: Config bit 1 set enables thermal shutdown, cleared disables it.
// R10: Config bit 0 set powers down by software, cleared powers up.
// R11: Four 8-bit source selects; bit 0 takes calibrated A, 1 takes B.
// R12: Final register straight binary code drives each converter's tap selection.
// R13: Select bits 0 to 7 steer channels 0 to 7 of the group.
// R14: Data, gain or offset writes recompute calibrated A or B per select bit.
// R15: Calibrated equals code times gain-plus-one over two-to-width, plus offset, minus half.
// R16: Word width is one parameter; trim arithmetic scales with it.
module dcrb_top (
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  // Avalon-MM slave
  input  wire logic [dcrb_pkg::ADDR_W-1:0]           avs_address,
  input  wire logic                                  avs_read,
  input  wire logic                                  avs_write,
  input  wire logic [dcrb_pkg::DATA_W-1:0]           avs_writedata,
  input  wire logic [dcrb_pkg::BE_W-1:0]             avs_byteenable,
  output logic      [dcrb_pkg::DATA_W-1:0]           avs_readdata,
  output logic                                       avs_waitrequest,
  // Converter side
  output logic [dcrb_pkg::CH_NUM-1:0][dcrb_pkg::WORD_W-1:0] tapCode,
  output logic      [dcrb_pkg::OFS_W-1:0]            group0OffsetLevel,
  output logic      [dcrb_pkg::OFS_W-1:0]            group123OffsetLevel,
  output dcrb_pkg::dcrb_cfg_s                        globalConfig
);
  import dcrb_pkg::*;

  // Bus sequencer
  dcrb_bus_e                  busState_reg;
  logic                       waitReq_reg;
  logic [DATA_W-1:0]          readData_reg;
  logic [DATA_W-1:0]          readData_next;

  // Per-channel storage
  logic [CH_NUM-1:0][WORD_W-1:0] inputDataA_reg;
  logic [CH_NUM-1:0][WORD_W-1:0] inputDataB_reg;
  logic [CH_NUM-1:0][WORD_W-1:0] gainTrim_reg;
  logic [CH_NUM-1:0][WORD_W-1:0] offsetTrim_reg;
  logic [CH_NUM-1:0][WORD_W-1:0] calibratedOutA_reg;
  logic [CH_NUM-1:0][WORD_W-1:0] calibratedOutB_reg;
  logic [CH_NUM-1:0][WORD_W-1:0] finalCode;

  // Global storage
  logic [OFS_W-1:0]              group0OffsetLevel_reg;
  logic [OFS_W-1:0]              group123OffsetLevel_reg;
  dcrb_cfg_s                     globalConfig_reg;
  logic [GRP_NUM-1:0][SEL_W-1:0] sourceSelect_reg;

  // Recompute request
  logic                      recalcPend_reg;
  logic [CH_IDX_W-1:0]       recalcCh_reg;
  logic                      recalcToB_reg;
  dcrb_word_t                recalcIn;
  dcrb_word_t                recalcOut;

  // Decode
  logic [2:0]                region;
  logic [CH_IDX_W-1:0]       chIdx;
  logic [1:0]                selIdx;
  logic                      wrTake;
  logic                      wrData;
  logic                      wrGain;
  logic                      wrOffset;
  logic                      wrSel;

  // Byte-lane merge; lanes above the word width are ignored
  function automatic dcrb_word_t mergeWord(input dcrb_word_t oldVal,
                                           input logic [DATA_W-1:0] wData,
                                           input logic [BE_W-1:0] be);
    dcrb_word_t res;
    res = oldVal;
    if (be[0]) begin
      res[LANE_W-1:0] = wData[LANE_W-1:0];
    end
    if (be[1]) begin
      res[WORD_W-1:LANE_W] = wData[WORD_W-1:LANE_W];
    end
    return res;
  endfunction : mergeWord

  // Channel index is group in the upper two bits, channel in group below [R1]
  assign region   = avs_address[ADDR_W-1:ADDR_W-3];
  assign chIdx    = avs_address[CH_IDX_W-1:0];
  assign selIdx   = 2'(avs_address - ADDR_SEL_BASE);

  // A write lands only at the edge where waitrequest is low
  assign wrTake   = (busState_reg == BUS_ANSWER) && avs_write;
  assign wrData   = wrTake && (region == REGION_INPUT_A);
  assign wrGain   = wrTake && (region == REGION_GAIN);
  assign wrOffset = wrTake && (region == REGION_OFFSET);
  assign wrSel    = wrTake && (avs_address >= ADDR_SEL_BASE) && (avs_address <= ADDR_SEL_LAST);

  // One wait state per access: request seen in idle, answered the cycle after
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_reg <= BUS_IDLE;
      waitReq_reg  <= 1'b1;
    end else begin
      unique case (busState_reg)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            busState_reg <= BUS_ANSWER;
            waitReq_reg  <= 1'b0;
          end
        end
        BUS_ANSWER: begin
          busState_reg <= BUS_IDLE;
          waitReq_reg  <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; calibrated and final registers have no read path [R4] [R5]
  always_comb begin
    readData_next = READ_ZERO;
    unique case (region)
      REGION_INPUT_A: readData_next[WORD_W-1:0] = inputDataA_reg[chIdx];
      REGION_INPUT_B: readData_next[WORD_W-1:0] = inputDataB_reg[chIdx];
      REGION_GAIN:    readData_next[WORD_W-1:0] = gainTrim_reg[chIdx];
      REGION_OFFSET:  readData_next[WORD_W-1:0] = offsetTrim_reg[chIdx];
      REGION_GLOBAL: begin
        if (avs_address == ADDR_GRP0_OFS) begin
          readData_next[OFS_W-1:0] = group0OffsetLevel_reg;
        end else if (avs_address == ADDR_GRP123_OFS) begin
          readData_next[OFS_W-1:0] = group123OffsetLevel_reg;
        end else if (avs_address == ADDR_CONFIG) begin
          readData_next[CFG_W-1:0] = globalConfig_reg;
        end else if ((avs_address >= ADDR_SEL_BASE) && (avs_address <= ADDR_SEL_LAST)) begin
          readData_next[SEL_W-1:0] = sourceSelect_reg[selIdx];
        end
      end
      default: readData_next = READ_ZERO;
    endcase
  end

  // Read data is captured on entry to the answer cycle and stands through it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readData_reg <= READ_ZERO;
    end else if ((busState_reg == BUS_IDLE) && avs_read) begin
      readData_reg <= readData_next;
    end
  end

  // Input data writes steered to A or B by the global select bit [R2] [R8]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inputDataA_reg <= {CH_NUM{RST_INPUT}};
      inputDataB_reg <= {CH_NUM{RST_INPUT}};
    end else if (wrData) begin
      if (globalConfig_reg.abSel) begin
        inputDataB_reg[chIdx] <= mergeWord(inputDataB_reg[chIdx], avs_writedata, avs_byteenable);
      end else begin
        inputDataA_reg[chIdx] <= mergeWord(inputDataA_reg[chIdx], avs_writedata, avs_byteenable);
      end
    end
  end

  // Per-channel gain and offset trim [R3]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gainTrim_reg   <= {CH_NUM{RST_GAIN}};
      offsetTrim_reg <= {CH_NUM{RST_OFFSET}};
    end else begin
      if (wrGain) begin
        gainTrim_reg[chIdx] <= mergeWord(gainTrim_reg[chIdx], avs_writedata, avs_byteenable);
      end
      if (wrOffset) begin
        offsetTrim_reg[chIdx] <= mergeWord(offsetTrim_reg[chIdx], avs_writedata,
                                           avs_byteenable);
      end
    end
  end

  // Group offset levels [R6] [R7]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      group0OffsetLevel_reg   <= RST_OFS;
      group123OffsetLevel_reg <= RST_OFS;
    end else if (wrTake && (avs_address == ADDR_GRP0_OFS)) begin
      group0OffsetLevel_reg <= OFS_W'(mergeWord(WORD_W'(group0OffsetLevel_reg),
                                                avs_writedata, avs_byteenable));
    end else if (wrTake && (avs_address == ADDR_GRP123_OFS)) begin
      group123OffsetLevel_reg <= OFS_W'(mergeWord(WORD_W'(group123OffsetLevel_reg),
                                                  avs_writedata, avs_byteenable));
    end
  end

  // Global configuration: select, thermal shutdown enable, power-down [R8] [R9] [R10]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      globalConfig_reg <= RST_CFG;
    end else if (wrTake && (avs_address == ADDR_CONFIG) && avs_byteenable[0]) begin
      globalConfig_reg <= avs_writedata[CFG_W-1:0];
    end
  end

  // Source selects, one per group, plus a command that fills all of them [R11]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sourceSelect_reg <= {GRP_NUM{RST_SEL}};
    end else if (wrTake && (avs_address == ADDR_SEL_ALL) && avs_byteenable[0]) begin
      sourceSelect_reg <= {GRP_NUM{avs_writedata[0] ? SEL_ALL_B : RST_SEL}};
    end else if (wrSel && avs_byteenable[0]) begin
      sourceSelect_reg[selIdx] <= avs_writedata[SEL_W-1:0];
    end
  end

  // Remember which calibrated word a write touched; the target follows the select bit [R14]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recalcPend_reg <= 1'b0;
      recalcCh_reg   <= '0;
      recalcToB_reg  <= 1'b0;
    end else begin
      recalcPend_reg <= wrData || wrGain || wrOffset;
      if (wrData || wrGain || wrOffset) begin
        recalcCh_reg  <= chIdx;
        recalcToB_reg <= globalConfig_reg.abSel;
      end
    end
  end

  // One shared multiplier-adder; a recompute lasts one cycle, so accesses never queue
  assign recalcIn = recalcToB_reg ? inputDataB_reg[recalcCh_reg] : inputDataA_reg[recalcCh_reg];

  dcrb_trim_calc u_trim_calc (
    .inCode     (recalcIn),
    .gainCode   (gainTrim_reg[recalcCh_reg]),
    .offsetCode (offsetTrim_reg[recalcCh_reg]),
    .calCode    (recalcOut)
  );

  // Calibrated registers are written only by the trim engine [R4] [R14] [R15]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calibratedOutA_reg <= {CH_NUM{RST_CAL}};
      calibratedOutB_reg <= {CH_NUM{RST_CAL}};
    end else if (recalcPend_reg) begin
      if (recalcToB_reg) begin
        calibratedOutB_reg[recalcCh_reg] <= recalcOut;
      end else begin
        calibratedOutA_reg[recalcCh_reg] <= recalcOut;
      end
    end
  end

  // Final converter registers, one group of eight per instance [R1] [R5]
  for (genvar g = 0; g < GRP_NUM; g++) begin : gen_group
    dcrb_source_mux u_source_mux (
      .clk       (clk),
      .rst_n     (rst_n),
      .calA      (calibratedOutA_reg[g*GRP_CH +: GRP_CH]),
      .calB      (calibratedOutB_reg[g*GRP_CH +: GRP_CH]),
      .srcSel    (sourceSelect_reg[g]),
      .finalCode (finalCode[g*GRP_CH +: GRP_CH])
    );
  end

  // Straight binary final codes are the tap selections [R12]
  assign tapCode             = finalCode;
  assign group0OffsetLevel   = group0OffsetLevel_reg;
  assign group123OffsetLevel = group123OffsetLevel_reg;
  assign globalConfig        = globalConfig_reg;
  assign avs_readdata        = readData_reg;
  assign avs_waitrequest     = waitReq_reg;

endmodule : dcrb_top

// ### hw/dcrb_pkg.sv
// Constants, types and register map of the converter channel register bank
package dcrb_pkg;

  // Geometry
  localparam int WORD_W    = 16;
  localparam int CH_NUM    = 32;
  localparam int GRP_NUM   = 4;
  localparam int GRP_CH    = 8;
  localparam int CH_IDX_W  = 5;
  localparam int OFS_W     = 14;
  localparam int CFG_W     = 3;
  localparam int SEL_W     = 8;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int BE_W      = 4;
  localparam int LANE_W    = 8;

  // Word-address map: top three address bits pick a region
  localparam logic [2:0]        REGION_INPUT_A = 3'h0;
  localparam logic [2:0]        REGION_INPUT_B = 3'h1;
  localparam logic [2:0]        REGION_GAIN    = 3'h2;
  localparam logic [2:0]        REGION_OFFSET  = 3'h3;
  localparam logic [2:0]        REGION_GLOBAL  = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_GRP0_OFS  = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_GRP123_OFS = 8'h81;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG    = 8'h82;
  localparam logic [ADDR_W-1:0] ADDR_SEL_ALL   = 8'h83;
  localparam logic [ADDR_W-1:0] ADDR_SEL_BASE  = 8'h84;
  localparam logic [ADDR_W-1:0] ADDR_SEL_LAST  = 8'h87;

  // Reset values, plus the select-all fill value
  localparam logic [WORD_W-1:0] RST_INPUT  = 16'h5554;
  localparam logic [WORD_W-1:0] RST_GAIN   = 16'hFFFF;
  localparam logic [WORD_W-1:0] RST_OFFSET = 16'h8000;
  localparam logic [WORD_W-1:0] RST_CAL    = 16'h5554;
  localparam logic [OFS_W-1:0]  RST_OFS    = 14'h1555;
  localparam logic [SEL_W-1:0]  RST_SEL    = 8'h00;
  localparam logic [SEL_W-1:0]  SEL_ALL_B  = 8'hFF;
  localparam logic [DATA_W-1:0] READ_ZERO  = 32'h0000_0000;

  // Global configuration word, bit 2 down to bit 0
  typedef struct packed {
    logic abSel;
    logic thermEn;
    logic powerDown;
  } dcrb_cfg_s;

  localparam dcrb_cfg_s RST_CFG = '{abSel: 1'b0, thermEn: 1'b0, powerDown: 1'b0};

  // Bus answer sequencer
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } dcrb_bus_e;

  typedef logic [WORD_W-1:0] dcrb_word_t;

endpackage : dcrb_pkg

// ### hw/dcrb_trim_calc.sv
// Shared gain and offset trim arithmetic
`timescale 1ns/1ns
module dcrb_trim_calc (
  // Operands
  input  wire dcrb_pkg::dcrb_word_t inCode,
  input  wire dcrb_pkg::dcrb_word_t gainCode,
  input  wire dcrb_pkg::dcrb_word_t offsetCode,
  // Result
  output dcrb_pkg::dcrb_word_t      calCode
);
  import dcrb_pkg::*;

  localparam logic signed [WORD_W+2:0] HALF_SCALE = (WORD_W+3)'(1) <<< (WORD_W-1);
  localparam logic signed [WORD_W+2:0] FULL_SCALE = (WORD_W+3)'((1 << WORD_W) - 1);

  logic        [WORD_W:0]   gainPlus;
  logic        [2*WORD_W:0] product;
  logic signed [WORD_W+2:0] sum;

  // Code times (gain+1) over 2^W, plus offset trim, minus half scale [R15] [R16]
  always_comb begin
    gainPlus = {1'b0, gainCode} + (WORD_W+1)'(1);
    product  = {(WORD_W+1)'(0), inCode} * {WORD_W'(0), gainPlus};
    sum      = $signed({2'b00, product[2*WORD_W:WORD_W]})
             + $signed({3'b000, offsetCode}) - HALF_SCALE;
  end

  // Out-of-range results saturate rather than wrap, so a bad trim never folds over
  always_comb begin
    if (sum < 0) begin
      calCode = '0;
    end else if (sum > FULL_SCALE) begin
      calCode = '1;
    end else begin
      calCode = sum[WORD_W-1:0];
    end
  end

endmodule : dcrb_trim_calc

// ### hw/dcrb_source_mux.sv
// One group of eight final converter registers with per-channel source choice
`timescale 1ns/1ns
module dcrb_source_mux (
  // Clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     rst_n,
  // Calibrated sources and per-channel choice
  input  wire logic [dcrb_pkg::GRP_CH-1:0][dcrb_pkg::WORD_W-1:0] calA,
  input  wire logic [dcrb_pkg::GRP_CH-1:0][dcrb_pkg::WORD_W-1:0] calB,
  input  wire logic [dcrb_pkg::SEL_W-1:0]               srcSel,
  // Final converter codes
  output logic [dcrb_pkg::GRP_CH-1:0][dcrb_pkg::WORD_W-1:0]      finalCode
);
  import dcrb_pkg::*;

  logic [GRP_CH-1:0][WORD_W-1:0] final_reg;

  // Final register follows only calibrated A or B; bit n steers channel n [R5] [R11] [R13]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      final_reg <= {GRP_CH{RST_CAL}};
    end else begin
      for (int i = 0; i < GRP_CH; i++) begin
        final_reg[i] <= srcSel[i] ? calB[i] : calA[i];
      end
    end
  end

  assign finalCode = final_reg;

endmodule : dcrb_source_mux

// ### bench/dcrb_top_assertions.sv
// Port-level checker of the converter register bank
`timescale 1ns/1ns
module dcrb_top_assertions (
  // Clock and reset
  input wire logic                                          clk,
  input wire logic                                          rst_n,
  // Avalon-MM slave
  input wire logic [dcrb_pkg::ADDR_W-1:0]                   avs_address,
  input wire logic                                          avs_read,
  input wire logic                                          avs_write,
  input wire logic [dcrb_pkg::DATA_W-1:0]                   avs_writedata,
  input wire logic [dcrb_pkg::BE_W-1:0]                     avs_byteenable,
  input wire logic [dcrb_pkg::DATA_W-1:0]                   avs_readdata,
  input wire logic                                          avs_waitrequest,
  // Converter side
  input wire logic [dcrb_pkg::CH_NUM-1:0][dcrb_pkg::WORD_W-1:0] tapCode,
  input wire logic [dcrb_pkg::OFS_W-1:0]                    group0OffsetLevel,
  input wire logic [dcrb_pkg::OFS_W-1:0]                    group123OffsetLevel,
  input wire dcrb_pkg::dcrb_cfg_s                           globalConfig
);
  import dcrb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    avs_waitrequest && (avs_read || avs_write);
  endsequence
  sequence s_cfgWr;
    s_taken ##0 avs_write && avs_address == ADDR_CONFIG && avs_byteenable[0];
  endsequence
  a_answer_next: assert property (s_taken |=> !avs_waitrequest)
    else $error("No answer one cycle after a request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Wait request low for more than one cycle");
  a_idle_wait: assert property (avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("Answer without a request");
  a_unmapped_zero: assert property (
    avs_waitrequest && avs_read && avs_address >= 8'h88 |=> avs_readdata == READ_ZERO)
    else $error("Unmapped read not zero");
  a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("Read data upper half not zero");
  a_cfg_write: assert property (
    s_cfgWr |=> ##1 globalConfig == $past(avs_writedata[2:0], 2))
    else $error("Config write not stored");
  a_cfg_hold: assert property (
    !$stable(globalConfig) |-> $past(avs_write && !avs_waitrequest && avs_address == ADDR_CONFIG))
    else $error("Config changed without a write");
  a_group0_offset_level_hold: assert property (
    !$stable(group0OffsetLevel) |-> $past(avs_write && avs_address == ADDR_GRP0_OFS))
    else $error("Group 0 offset changed without a write");
  a_ofs123_hold: assert property (
    !$stable(group123OffsetLevel) |-> $past(avs_write && avs_address == ADDR_GRP123_OFS))
    else $error("Group 1-3 offset changed without a write");
  a_tap_cause: assert property (
    !$stable(tapCode) |-> $past(avs_write, 2) || $past(avs_write, 3))
    else $error("Converter code changed without a write");
  a_read_stable: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
    else $error("Read data changed outside an answer");
endmodule : dcrb_top_assertions

bind dcrb_top dcrb_top_assertions u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tapCode(tapCode),
  .group0OffsetLevel(group0OffsetLevel), .group123OffsetLevel(group123OffsetLevel),
  .globalConfig(globalConfig)
);

// ### bench/dcrb_host.sv
// Host model issuing Avalon-MM register accesses
`timescale 1ns/1ns
module dcrb_host (
  // Clock and answer
  input  wire logic                        clk,
  input  wire logic                        waitReq,
  input  wire logic [dcrb_pkg::DATA_W-1:0] readData,
  // Request
  output logic      [dcrb_pkg::ADDR_W-1:0] address,
  output logic                             read,
  output logic                             write,
  output logic      [dcrb_pkg::DATA_W-1:0] writeData,
  output logic      [dcrb_pkg::BE_W-1:0]   byteEnable
);
  import dcrb_pkg::*;
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writeData = '0;
    byteEnable = 4'hF;
  end
  // Holds the request until waitrequest is seen low; a dead slave is left to the watchdog
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [BE_W-1:0] e,
                        output logic [DATA_W-1:0] q);
    @(posedge clk);
    address <= a;
    writeData <= d;
    byteEnable <= e;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitReq !== 1'b0);
    q = readData;
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show garbage, not the last value
    address <= ~a;
    writeData <= ~d;
  endtask : access
endmodule : dcrb_host

// ### bench/tb_dcrb_top.sv
// Self-checking bench of the converter register bank
`timescale 1ns/1ns
module tb_dcrb_top;
  import dcrb_pkg::*;
  logic                          clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic [ADDR_W-1:0]             adr;
  logic                          rd;
  logic                          wr;
  logic [DATA_W-1:0]             wd;
  logic [DATA_W-1:0]             rdat;
  logic [BE_W-1:0]               be;
  logic                          wreq;
  logic [CH_NUM-1:0][WORD_W-1:0] tap;
  logic [OFS_W-1:0]              group0_offset_level;
  logic [OFS_W-1:0]              group123_offset_level;
  dcrb_cfg_s                     cfg;
  dcrb_word_t                    mIn[2][CH_NUM];
  dcrb_word_t                    mCal[2][CH_NUM];
  dcrb_word_t                    mGain[CH_NUM];
  dcrb_word_t                    mOff[CH_NUM];
  logic [SEL_W-1:0]              mSel[GRP_NUM];
  logic [OFS_W-1:0]              mOfs[2];
  logic [CFG_W-1:0]              mCfg;
  logic [31:0]                   seed = 32'h0000_4026;
  int                            n_mismatch = 0;
  int                            n_checks = 0;
  localparam logic [23:0] CORNER [18] = '{24'h82_0000, 24'h00_FFFF, 24'h40_FFFF,
    24'h60_FFFF, 24'h01_0000, 24'h61_0000, 24'h82_0004, 24'h01_1234, 24'h84_0002,
    24'h41_8000, 24'h83_0001, 24'h83_0000, 24'h25_BEEF, 24'h90_FFFF, 24'h82_0003,
    24'h81_3FFF, 24'h80_0001, 24'h87_0080};

  always #5 clk = ~clk;

  dcrb_top dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .tapCode(tap), .group0OffsetLevel(group0_offset_level), .group123OffsetLevel(group123_offset_level), .globalConfig(cfg));
  dcrb_host host (.clk(clk), .waitReq(wreq), .readData(rdat), .address(adr), .read(rd),
    .write(wr), .writeData(wd), .byteEnable(be));

  function automatic logic [31:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xrand

  // Saturates instead of wrapping, matching the chosen overflow handling
  function automatic dcrb_word_t calc(dcrb_word_t x, dcrb_word_t g, dcrb_word_t c);
    longint r;
    r = ((longint'(x) * (longint'(g) + 1)) >> WORD_W) + longint'(c) - (64'sd1 << (WORD_W - 1));
    if (r < 0) r = 0;
    if (r > (64'sd1 << WORD_W) - 1) r = (64'sd1 << WORD_W) - 1;
    return dcrb_word_t'(r);
  endfunction : calc

  function automatic logic [DATA_W-1:0] expRead(logic [ADDR_W-1:0] a);
    case (a[7:5])
      3'h0: return {16'h0000, mIn[0][a[4:0]]};
      3'h1: return {16'h0000, mIn[1][a[4:0]]};
      3'h2: return {16'h0000, mGain[a[4:0]]};
      3'h3: return {16'h0000, mOff[a[4:0]]};
      default: ;
    endcase
    if (a == ADDR_GRP0_OFS) return {18'h0, mOfs[0]};
    if (a == ADDR_GRP123_OFS) return {18'h0, mOfs[1]};
    if (a == ADDR_CONFIG) return {29'h0, mCfg};
    if (a >= ADDR_SEL_BASE && a <= ADDR_SEL_LAST) return {24'h0, mSel[a[1:0]]};
    return READ_ZERO;
  endfunction : expRead

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic initModel();
    for (int ch = 0; ch < CH_NUM; ch++) begin
      mIn[0][ch] = RST_INPUT;
      mIn[1][ch] = RST_INPUT;
      mCal[0][ch] = RST_CAL;
      mCal[1][ch] = RST_CAL;
      mGain[ch] = RST_GAIN;
      mOff[ch] = RST_OFFSET;
    end
    mSel = '{default: RST_SEL};
    mOfs = '{default: RST_OFS};
    mCfg = RST_CFG;
  endtask : initModel

  task automatic checkAll();
    dcrb_word_t e;
    repeat (3) @(posedge clk);
    for (int ch = 0; ch < CH_NUM; ch++) begin
      e = mSel[ch / GRP_CH][ch % GRP_CH] ? mCal[1][ch] : mCal[0][ch];
      check("tapCode", tap[ch], e);
    end
    check("group0OffsetLevel", group0_offset_level, mOfs[0]);
    check("group123OffsetLevel", group123_offset_level, mOfs[1]);
    check("globalConfig", cfg, mCfg);
  endtask : checkAll

  task automatic readChk(logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] q;
    host.access(1'b0, a, '0, 4'hF, q);
    check("readdata", q, expRead(a));
  endtask : readChk

  task automatic doOp(logic [ADDR_W-1:0] a, dcrb_word_t d, logic [1:0] e);
    logic [DATA_W-1:0] q;
    dcrb_word_t o;
    int s;
    s = mCfg[2];
    // Lanes left off keep the old bits; select-all needs lane 0
    q = expRead(a);
    o = (a[7:5] == 3'h0) ? mIn[s][a[4:0]] : q[WORD_W-1:0];
    host.access(1'b1, a, {16'h0000, d}, {2'b11, e}, q);
    d = {e[1] ? d[15:8] : o[15:8], e[0] ? d[7:0] : o[7:0]};
    case (a[7:5])
      3'h0: mIn[s][a[4:0]] = d;
      3'h2: mGain[a[4:0]] = d;
      3'h3: mOff[a[4:0]] = d;
      default: ;
    endcase
    if (a[7:5] == 3'h0 || a[7:5] == 3'h2 || a[7:5] == 3'h3) begin
      mCal[s][a[4:0]] = calc(mIn[s][a[4:0]], mGain[a[4:0]], mOff[a[4:0]]);
    end
    if (a == ADDR_GRP0_OFS) mOfs[0] = d[OFS_W-1:0];
    if (a == ADDR_GRP123_OFS) mOfs[1] = d[OFS_W-1:0];
    if (a == ADDR_CONFIG) mCfg = d[CFG_W-1:0];
    if (a == ADDR_SEL_ALL && e[0]) mSel = '{default: d[0] ? SEL_ALL_B : RST_SEL};
    if (a >= ADDR_SEL_BASE && a <= ADDR_SEL_LAST) mSel[a[1:0]] = d[SEL_W-1:0];
    checkAll();
    readChk(a);
  endtask : doOp

  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end

  initial begin
    logic [31:0] r;
    initModel();
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    checkAll();
    for (int i = 0; i < 8; i++) begin
      readChk(ADDR_W'(i * 17));
      readChk(ADDR_GRP0_OFS + ADDR_W'(i));
    end
    foreach (CORNER[i]) doOp(CORNER[i][23:16], CORNER[i][15:0], 2'b11);
    // Random traffic, biased toward the global registers so they are hit often
    for (int i = 0; i < 200; i++) begin
      r = xrand();
      repeat (r[9:8]) @(posedge clk);
      doOp(r[10] ? {5'h10, r[2:0]} : r[7:0], r[31:16], r[11] ? 2'b11 : r[13:12]);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    initModel();
    checkAll();
    readChk(8'h47);
    readChk(ADDR_CONFIG);
    @(posedge clk);
    check("waitrequest", wreq, 1'b1);
    test_done();
  end
endmodule : tb_dcrb_top
